// file: bench/tb.sv
// self-checking bench for the subtract/xor/swap execute block
`timescale 1ns/100ps
module tb;
  import sxs_pkg::*;
  typedef struct {
    logic [7:0] acc, wd, da, db, dx;
    logic [6:0] wa;
    logic       c, dc, z, to, pd, we, sl, wz;
  } sxs_note_t;
  logic mclk, rst, clk_en, instr_valid, result_target_bit, borrow_inverse_bit_in, wake_event;
  sxs_op_t    instr_op;
  logic [7:0] literal_byte, reg_read_data, reg_write_data, accumulator_reg, watchdog_counter;
  logic [7:0] watchdog_prescaler, port_a_direction, port_b_direction, port_c_direction;
  logic [6:0] operand_reg_address, reg_write_address;
  logic       reg_write_en, borrow_inverse_bit, low_nibble_carry, result_null_flag;
  logic       timeout_flag, powerdown_flag, sleep_mode, osc_halt;
  int         fail_count = 0;
  int         checks = 0;
  int         cycles = 0;
  integer     seed = 32'h21ac;
  sxs_note_t  q[$];
  sxs_note_t  m = '{acc: 8'h00, da: 8'hff, db: 8'hff, dx: 8'hff, to: 1'b1, pd: 1'b1, default: 0};

  sxs_execute u_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr_op(instr_op), .literal_byte(literal_byte), .operand_reg_address(operand_reg_address),
    .result_target_bit(result_target_bit), .reg_read_data(reg_read_data),
    .borrow_inverse_bit_in(borrow_inverse_bit_in), .wake_event(wake_event),
    .reg_write_en(reg_write_en), .reg_write_address(reg_write_address),
    .reg_write_data(reg_write_data), .accumulator_reg(accumulator_reg),
    .borrow_inverse_bit(borrow_inverse_bit), .low_nibble_carry(low_nibble_carry),
    .result_null_flag(result_null_flag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .watchdog_counter(watchdog_counter),
    .watchdog_prescaler(watchdog_prescaler), .sleep_mode(sleep_mode), .osc_halt(osc_halt),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // reference model runs in the issuing process, so the note matches what was driven
  task automatic issue(input sxs_op_t op, input logic [7:0] lit, input logic [6:0] adr,
                       input logic d, input logic [7:0] rd, input logic en);
    logic [7:0] a, res;
    logic       cin;
    @(negedge mclk);
    clk_en = en;
    instr_valid = 1'b1;
    instr_op = op;
    literal_byte = lit;
    operand_reg_address = adr;
    result_target_bit = d;
    reg_read_data = rd;
    borrow_inverse_bit_in = 1'($random(seed));
    // a low clock enable freezes the write strobe too, so the note keeps it
    if (en) begin
      m.we = 1'b0;
      m.wz = 1'b0;
    end
    if (en && !m.sl) begin
      cin = (op == SXS_OP_REG_MINUS_ACC_BORROW) ? m.c : 1'b1;
      a = (op inside {SXS_OP_LITERAL_MINUS_ACC, SXS_OP_LITERAL_EXCLUSIVE_OR}) ? lit : rd;
      case (op)
        SXS_OP_LITERAL_MINUS_ACC, SXS_OP_REG_MINUS_ACC, SXS_OP_REG_MINUS_ACC_BORROW: begin
          res = a - m.acc - {7'h00, !cin};
          m.c = {1'b0, a} >= ({1'b0, m.acc} + {8'h00, !cin});
          m.dc = {1'b0, a[3:0]} >= ({1'b0, m.acc[3:0]} + {4'h0, !cin});
          m.z = (res == 8'h00);
        end
        SXS_OP_LITERAL_EXCLUSIVE_OR, SXS_OP_REG_EXCLUSIVE_OR: begin
          res = m.acc ^ a;
          m.z = (res == 8'h00);
        end
        SXS_OP_NIBBLE_EXCHANGE: res = {rd[3:0], rd[7:4]};
        SXS_OP_DIRECTION_LOAD: begin
          if (adr == SXS_DIR_A) m.da = m.acc;
          if (adr == SXS_DIR_B) m.db = m.acc;
          if (adr == SXS_DIR_C) m.dx = m.acc;
        end
        SXS_OP_SLEEP: begin
          m.to = 1'b1;
          m.pd = 1'b0;
          m.sl = 1'b1;
          m.wz = 1'b1;
        end
        default: ;
      endcase
      if (op inside {SXS_OP_LITERAL_MINUS_ACC, SXS_OP_LITERAL_EXCLUSIVE_OR}) m.acc = res;
      else if (op inside {SXS_OP_REG_MINUS_ACC, SXS_OP_REG_MINUS_ACC_BORROW,
                          SXS_OP_REG_EXCLUSIVE_OR, SXS_OP_NIBBLE_EXCHANGE}) begin
        if (d) begin
          m.we = 1'b1;
          m.wa = adr;
          m.wd = res;
        end else m.acc = res;
      end
    end
    q.push_back(m);
  endtask : issue

  always begin
    sxs_note_t n;
    @(posedge mclk);
    #1;
    if (q.size() > 0) begin
      n = q.pop_front();
      check(accumulator_reg, n.acc);
      check({7'h00, borrow_inverse_bit}, {7'h00, n.c});
      check({7'h00, low_nibble_carry}, {7'h00, n.dc});
      check({7'h00, result_null_flag}, {7'h00, n.z});
      check({6'h00, timeout_flag, powerdown_flag}, {6'h00, n.to, n.pd});
      check({7'h00, reg_write_en}, {7'h00, n.we});
      if (n.we) check(reg_write_data, n.wd);
      if (n.we) check({1'b0, reg_write_address}, {1'b0, n.wa});
      check(port_a_direction, n.da);
      check(port_b_direction, n.db);
      check(port_c_direction, n.dx);
      check({6'h00, sleep_mode, osc_halt}, {6'h00, n.sl, n.sl});
      if (n.wz) check(watchdog_counter | watchdog_prescaler, SXS_WDT_CLR | SXS_PRE_CLR);
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] r;
    {rst, clk_en, instr_valid, result_target_bit, wake_event} = 5'b11000;
    {literal_byte, reg_read_data, operand_reg_address} = '0;
    borrow_inverse_bit_in = 1'b0;
    instr_op = SXS_OP_NONE;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    check(accumulator_reg, SXS_ACC_RST);
    check(port_b_direction, SXS_DIR_RST);
    check({6'h00, timeout_flag, powerdown_flag}, {6'h00, SXS_TO_RST, SXS_PD_RST});
    // equal operands: zero result with no borrow on both carries
    issue(SXS_OP_LITERAL_EXCLUSIVE_OR, 8'h5a, 7'h00, 1'b0, 8'h00, 1'b1);
    issue(SXS_OP_LITERAL_MINUS_ACC, 8'h5a, 7'h00, 1'b0, 8'h00, 1'b1);
    issue(SXS_OP_LITERAL_MINUS_ACC, 8'h01, 7'h00, 1'b0, 8'h00, 1'b1);
    issue(SXS_OP_REG_MINUS_ACC_BORROW, 8'h00, 7'h12, 1'b1, 8'h03, 1'b1);
    issue(SXS_OP_REG_MINUS_ACC_BORROW, 8'h00, 7'h12, 1'b0, 8'h03, 1'b1);
    for (int i = 4; i < 8; i++) issue(SXS_OP_DIRECTION_LOAD, 8'h00, 7'(i), 1'b0, 8'h00, 1'b1);
    issue(SXS_OP_LITERAL_EXCLUSIVE_OR, 8'h33, 7'h00, 1'b0, 8'h00, 1'b0);
    for (int i = 0; i < 120; i++) begin
      r = $random(seed);
      issue(sxs_op_t'(4'd1 + 4'(r[7:0] % 7)), 8'($random(seed)), r[22:16], r[8],
            8'($random(seed)), r[30:27] != 4'h0);
    end
    issue(SXS_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00, 1'b1);
    issue(SXS_OP_LITERAL_EXCLUSIVE_OR, 8'hff, 7'h00, 1'b0, 8'h00, 1'b1);
    @(negedge mclk);
    instr_valid = 1'b0;
    wake_event = 1'b1;
    @(negedge mclk);
    wake_event = 1'b0;
    @(negedge mclk);
    check({7'h00, sleep_mode}, 8'h00);
    m.sl = 1'b0;
    issue(SXS_OP_REG_EXCLUSIVE_OR, 8'h00, 7'h40, 1'b1, 8'ha5, 1'b1);
    @(negedge mclk);
    instr_valid = 1'b0;
    repeat (3) @(negedge mclk);
    end_of_test();
  end
endmodule : tb

// file: hw/sxs_alu.sv
// combinational arithmetic unit for subtract, exclusive-or and nibble swap
`timescale 1ns/100ps
module sxs_alu (
  sxs_alu_if.alu bus
);
  import sxs_pkg::*;

  // minuend - subtrahend - borrow; no-borrow carry out, nibble carry out
  function automatic logic [9:0] sxs_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return {full[8], low[4], full[7:0]};
  endfunction : sxs_sub

  logic [9:0] diff;

  always_comb begin
    diff          = sxs_sub(bus.opnd, bus.acc, bus.carry_in);
    bus.result    = bus.opnd;
    bus.carry_out = 1'b0;
    bus.nib_out   = 1'b0;
    case (bus.op)
      SXS_OP_LITERAL_MINUS_ACC, SXS_OP_REG_MINUS_ACC, SXS_OP_REG_MINUS_ACC_BORROW: begin
        bus.result    = diff[7:0];
        bus.carry_out = diff[9];
        bus.nib_out   = diff[8];
      end
      SXS_OP_LITERAL_EXCLUSIVE_OR, SXS_OP_REG_EXCLUSIVE_OR: begin
        bus.result = bus.acc ^ bus.opnd;
      end
      SXS_OP_NIBBLE_EXCHANGE: begin
        bus.result = {bus.opnd[3:0], bus.opnd[7:4]};
      end
      default: begin
        bus.result = bus.opnd;
      end
    endcase
    bus.zero_out = (bus.result == 8'h00);
  end
endmodule : sxs_alu

// file: hw/sxs_execute.sv
// execute stage: subtract, exclusive-or, swap, direction load and sleep
`timescale 1ns/100ps
module sxs_execute #(
  parameter int DW = sxs_pkg::SXS_DW,
  parameter int AW = sxs_pkg::SXS_AW
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // instruction issue
  input  wire logic             instr_valid,
  input  wire sxs_pkg::sxs_op_t instr_op,
  input  wire logic [7:0]       literal_byte,
  input  wire logic [6:0]       operand_reg_address,
  input  wire logic             result_target_bit,
  // register file read data and status in
  input  wire logic [7:0]       reg_read_data,
  input  wire logic             borrow_inverse_bit_in,
  input  wire logic             wake_event,
  // register file write back
  output logic                  reg_write_en,
  output logic [6:0]            reg_write_address,
  output logic [7:0]            reg_write_data,
  // accumulator and status
  output logic [7:0]            accumulator_reg,
  output logic                  borrow_inverse_bit,
  output logic                  low_nibble_carry,
  output logic                  result_null_flag,
  output logic                  timeout_flag,
  output logic                  powerdown_flag,
  // watchdog, sleep, port directions
  output logic [7:0]            watchdog_counter,
  output logic [7:0]            watchdog_prescaler,
  output logic                  sleep_mode,
  output logic                  osc_halt,
  output logic [7:0]            port_a_direction,
  output logic [7:0]            port_b_direction,
  output logic [7:0]            port_c_direction
);
  import sxs_pkg::*;

  if (DW != 8 || AW != 7) begin : g_chk
    $error("sxs_execute supports only an 8-bit datapath and 7-bit file address");
  end

  sxs_alu_if alu_bus ();
  sxs_alu u_alu (.bus(alu_bus.alu));

  logic [7:0] acc_ff, nxt_acc;
  logic       c_ff, nxt_c, dc_ff, nxt_dc, z_ff, nxt_z, to_ff, nxt_to, pd_ff, nxt_pd;
  logic [7:0] wdt_ff, nxt_wdt, pre_ff, nxt_pre;
  logic       slp_ff, nxt_slp;
  logic [7:0] tra_ff, nxt_tra, trb_ff, nxt_trb, trc_ff, nxt_trc;
  logic       we_ff, nxt_we;
  logic [6:0] wa_ff, nxt_wa;
  logic [7:0] wd_ff, nxt_wd;
  logic       is_literal, is_sub, is_xor, has_dest;

  // flag feedback uses the internally held carry so back-to-back borrows chain
  always_comb begin
    is_literal = (instr_op == SXS_OP_LITERAL_MINUS_ACC) ||
                 (instr_op == SXS_OP_LITERAL_EXCLUSIVE_OR);
    is_sub     = (instr_op == SXS_OP_LITERAL_MINUS_ACC) ||
                 (instr_op == SXS_OP_REG_MINUS_ACC) ||
                 (instr_op == SXS_OP_REG_MINUS_ACC_BORROW);
    is_xor     = (instr_op == SXS_OP_LITERAL_EXCLUSIVE_OR) ||
                 (instr_op == SXS_OP_REG_EXCLUSIVE_OR);
    has_dest   = (instr_op == SXS_OP_REG_MINUS_ACC) ||
                 (instr_op == SXS_OP_REG_MINUS_ACC_BORROW) ||
                 (instr_op == SXS_OP_NIBBLE_EXCHANGE) ||
                 (instr_op == SXS_OP_REG_EXCLUSIVE_OR);
    alu_bus.op       = instr_op;
    alu_bus.acc      = acc_ff;
    alu_bus.opnd     = is_literal ? literal_byte : reg_read_data;
    // plain subtracts carry in one: no borrow
    alu_bus.carry_in = (instr_op == SXS_OP_REG_MINUS_ACC_BORROW) ? c_ff : 1'b1;
  end

  always_comb begin
    nxt_acc = acc_ff;
    nxt_c   = c_ff;
    nxt_dc  = dc_ff;
    nxt_z   = z_ff;
    nxt_to  = to_ff;
    nxt_pd  = pd_ff;
    nxt_wdt = wdt_ff;
    nxt_pre = pre_ff;
    nxt_slp = slp_ff;
    nxt_tra = tra_ff;
    nxt_trb = trb_ff;
    nxt_trc = trc_ff;
    nxt_we  = 1'b0;
    nxt_wa  = wa_ff;
    nxt_wd  = wd_ff;
    // sleep holds until a wake event; instructions are ignored meanwhile
    if (slp_ff && wake_event) begin
      nxt_slp = 1'b0;
    end
    if (instr_valid && !slp_ff) begin
      if (is_literal) begin
        nxt_acc = alu_bus.result;
      end
      if (has_dest) begin
        if (result_target_bit == SXS_DEST_ACC) begin
          nxt_acc = alu_bus.result;
        end else begin
          nxt_we = 1'b1;
          nxt_wa = operand_reg_address;
          nxt_wd = alu_bus.result;
        end
      end
      if (is_sub) begin
        nxt_c  = alu_bus.carry_out;
        nxt_dc = alu_bus.nib_out;
      end
      if (is_sub || is_xor) begin
        nxt_z = alu_bus.zero_out;
      end
      if (instr_op == SXS_OP_DIRECTION_LOAD) begin
        case (operand_reg_address)
          SXS_DIR_A: nxt_tra = acc_ff;
          SXS_DIR_B: nxt_trb = acc_ff;
          SXS_DIR_C: nxt_trc = acc_ff;
          default: nxt_tra = tra_ff;
        endcase
      end
      if (instr_op == SXS_OP_SLEEP) begin
        nxt_wdt = SXS_WDT_CLR;
        nxt_pre = SXS_PRE_CLR;
        nxt_slp = 1'b1;
        nxt_to  = 1'b1;
        nxt_pd  = 1'b0;
      end
    end else if (!slp_ff) begin
      // watchdog counts while awake, only on cycles with no valid instruction
      {nxt_wdt, nxt_pre} = 16'({wdt_ff, pre_ff} + 16'h0001);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_ff <= SXS_ACC_RST;
      c_ff   <= 1'b0;
      dc_ff  <= 1'b0;
      z_ff   <= 1'b0;
      to_ff  <= SXS_TO_RST;
      pd_ff  <= SXS_PD_RST;
      wdt_ff <= SXS_WDT_CLR;
      pre_ff <= SXS_PRE_CLR;
      slp_ff <= 1'b0;
      tra_ff <= SXS_DIR_RST;
      trb_ff <= SXS_DIR_RST;
      trc_ff <= SXS_DIR_RST;
      we_ff  <= 1'b0;
      wa_ff  <= 7'h00;
      wd_ff  <= 8'h00;
    end else if (clk_en) begin
      acc_ff <= nxt_acc;
      c_ff   <= nxt_c;
      dc_ff  <= nxt_dc;
      z_ff   <= nxt_z;
      to_ff  <= nxt_to;
      pd_ff  <= nxt_pd;
      wdt_ff <= nxt_wdt;
      pre_ff <= nxt_pre;
      slp_ff <= nxt_slp;
      tra_ff <= nxt_tra;
      trb_ff <= nxt_trb;
      trc_ff <= nxt_trc;
      we_ff  <= nxt_we;
      wa_ff  <= nxt_wa;
      wd_ff  <= nxt_wd;
    end
  end

  // borrow_inverse_bit_in unused: carry is kept locally
  always_comb begin
    accumulator_reg    = acc_ff;
    borrow_inverse_bit = c_ff;
    low_nibble_carry   = dc_ff;
    result_null_flag   = z_ff;
    timeout_flag       = to_ff;
    powerdown_flag     = pd_ff;
    watchdog_counter   = wdt_ff;
    watchdog_prescaler = pre_ff;
    sleep_mode         = slp_ff;
    osc_halt           = slp_ff;
    port_a_direction   = tra_ff;
    port_b_direction   = trb_ff;
    port_c_direction   = trc_ff;
    reg_write_en       = we_ff;
    reg_write_address  = wa_ff;
    reg_write_data     = wd_ff;
  end

  a_lit_sub_acc: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_LITERAL_MINUS_ACC |=>
    acc_ff == 8'($past(literal_byte) - $past(acc_ff)))
    else $error("literal subtract result wrong");
  a_lit_sub_c: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_LITERAL_MINUS_ACC |=>
    c_ff == ($past(acc_ff) <= $past(literal_byte)) &&
    dc_ff == ($past(acc_ff[3:0]) <= $past(literal_byte[3:0])))
    else $error("literal subtract flags wrong");
  a_sleep_wdt: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_SLEEP |=>
    wdt_ff == 8'h00 && pre_ff == 8'h00 && slp_ff && osc_halt)
    else $error("sleep did not clear watchdog");
  a_sleep_flags: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_SLEEP |=>
    to_ff && !pd_ff && $stable(c_ff) && $stable(z_ff) && $stable(dc_ff))
    else $error("sleep status flags wrong");
  a_reg_sub_c: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_REG_MINUS_ACC |=>
    c_ff == ($past(acc_ff) <= $past(reg_read_data)))
    else $error("register subtract carry wrong");
  a_dest_file: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && has_dest && result_target_bit |=>
    we_ff && wa_ff == $past(operand_reg_address) && $stable(acc_ff))
    else $error("file destination not written");
  a_swap_data: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_NIBBLE_EXCHANGE &&
    result_target_bit |=> wd_ff == {$past(reg_read_data[3:0]), $past(reg_read_data[7:4])})
    else $error("nibble swap wrong");
  a_dir_b: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_DIRECTION_LOAD &&
    operand_reg_address == 7'h06 |=> trb_ff == $past(acc_ff) && $stable(tra_ff))
    else $error("direction load b wrong");
  a_xor_zero: assert property (@(posedge mclk) disable iff (rst)
    clk_en && instr_valid && !slp_ff && instr_op == SXS_OP_LITERAL_EXCLUSIVE_OR |=>
    z_ff == ($past(acc_ff) == $past(literal_byte)) && $stable(c_ff))
    else $error("xor zero flag wrong");
endmodule : sxs_execute

// file: shared/sxs_alu_if.sv
// interface: operands and results between execute control and the arithmetic unit
`timescale 1ns/100ps
interface sxs_alu_if;
  import sxs_pkg::*;
  sxs_op_t    op;
  logic [7:0] acc;
  logic [7:0] opnd;
  logic       carry_in;
  logic [7:0] result;
  logic       carry_out;
  logic       nib_out;
  logic       zero_out;
  modport ctl (output op, acc, opnd, carry_in, input result, carry_out, nib_out, zero_out);
  modport alu (input op, acc, opnd, carry_in, output result, carry_out, nib_out, zero_out);
endinterface : sxs_alu_if

// file: shared/sxs_pkg.sv
// package: opcodes, widths and reset values for the subtract/xor/swap execute block
package sxs_pkg;
  localparam int SXS_DW = 8;
  localparam int SXS_AW = 7;
  localparam int SXS_NIB = 4;
  localparam logic [7:0] SXS_ACC_RST = 8'h00;
  localparam logic [7:0] SXS_DIR_RST = 8'hff;
  localparam logic [7:0] SXS_WDT_CLR = 8'h00;
  localparam logic [7:0] SXS_PRE_CLR = 8'h00;
  localparam logic [6:0] SXS_DIR_A = 7'h05;
  localparam logic [6:0] SXS_DIR_B = 7'h06;
  localparam logic [6:0] SXS_DIR_C = 7'h07;
  localparam logic SXS_DEST_ACC = 1'b0;
  localparam logic SXS_TO_RST = 1'b1;
  localparam logic SXS_PD_RST = 1'b1;
  typedef enum logic [3:0] {
    SXS_OP_NONE,
    SXS_OP_LITERAL_MINUS_ACC,
    SXS_OP_REG_MINUS_ACC,
    SXS_OP_REG_MINUS_ACC_BORROW,
    SXS_OP_NIBBLE_EXCHANGE,
    SXS_OP_DIRECTION_LOAD,
    SXS_OP_LITERAL_EXCLUSIVE_OR,
    SXS_OP_REG_EXCLUSIVE_OR,
    SXS_OP_SLEEP
  } sxs_op_t;
endpackage : sxs_pkg
